// file: hw/phc_pkg.sv
package phc_pkg;
	localparam int NUM_OUT = 4;
	localparam int NUM_IN = 4;
	localparam int NUM_AXES = 3;
	localparam int UVAR_AW = 8;
	localparam int UVAR_DEPTH = 256;
	localparam int FRAME_BYTES = 9;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'h8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	// command opcodes
	localparam logic [7:0] OP_STORE_UVAR = 8'h0b;
	localparam logic [7:0] OP_RESTORE_UVAR = 8'h0c;
	localparam logic [7:0] OP_HOMING = 8'h0d;
	localparam logic [7:0] OP_SET_OUTPUT = 8'h0e;
	localparam logic [7:0] OP_READ_PORT = 8'h0f;

	localparam logic [7:0] BANK_DIN = 8'h00;
	localparam logic [7:0] BANK_AIN = 8'h01;
	localparam logic [7:0] BANK_DOUT = 8'h02;
	localparam logic [7:0] BANK_UVAR = 8'h02;

	localparam logic [7:0] HOME_START = 8'h00;
	localparam logic [7:0] HOME_STOP = 8'h01;
	localparam logic [7:0] HOME_STATUS = 8'h02;

	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_CSUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;

	localparam logic [7:0] HOST_ADDR = 8'h02;
	localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;
	localparam logic [7:0] PORT_COUNT = 8'h04;
	localparam logic [7:0] AXIS_COUNT = 8'h03;
	localparam logic [UVAR_AW-1:0] UVAR_LAST = 8'hff;
	localparam logic [UVAR_AW-1:0] UVAR_FIRST = 8'h00;
	localparam logic [31:0] VAL_ZERO = 32'h0000_0000;
	localparam logic [31:0] VAL_ONE = 32'h0000_0001;
	localparam logic [15:0] PAD16 = 16'h0000;

	typedef struct packed {
		logic [7:0] target;
		logic [7:0] opcode;
		logic [7:0] typ;
		logic [7:0] bank;
		logic [31:0] value;
	} phc_frame_s;

	typedef logic [NUM_IN-1:0][15:0] phc_ain_t;

	typedef enum logic [2:0] {
		S_BOOT, S_RX, S_EXEC, S_MEM_RD, S_NV_RD, S_NV_WR, S_TX
	} phc_state_e;
endpackage : phc_pkg

// file: hw/phc_uvar_mem.sv
`timescale 1ns/1ps
`default_nettype none
module phc_uvar_mem (
	input wire logic ref_clk_i, // clock
	input wire logic a_we_i, // port a write enable
	input wire logic [phc_pkg::UVAR_AW-1:0] a_addr_i, // port a address
	input wire logic [31:0] a_wdata_i, // port a write data
	output logic [31:0] a_rdata_o, // port a read data, registered
	input wire logic [phc_pkg::UVAR_AW-1:0] b_addr_i, // port b address
	output logic [31:0] b_rdata_o // port b read data, registered
);
	import phc_pkg::*;

	logic [31:0] mem_q [UVAR_DEPTH];
	logic [31:0] a_rdata_q;
	logic [31:0] b_rdata_q;

	// no reset: contents are filled by the power-up restore
	always_ff @(posedge ref_clk_i) begin
		if (a_we_i) begin
			mem_q[a_addr_i] <= a_wdata_i;
		end
		a_rdata_q <= mem_q[a_addr_i];
		b_rdata_q <= mem_q[b_addr_i];
	end

	assign a_rdata_o = a_rdata_q;
	assign b_rdata_o = b_rdata_q;
endmodule : phc_uvar_mem
`default_nettype wire

// file: hw/phc_cmd.sv
// How it works
// R1: opcode 11, bank 2 copies the typed user variable into nonvolatile memory.
// R2: opcode 12, bank 2 reloads the typed user variable from nonvolatile memory.
// R3: after reset all user variables reload from nonvolatile memory automatically.
// R4: opcode 13 starts, stops or queries homing of the axis in bank.
// R5: homing query replies zero when idle, nonzero while a search runs.
// R6: opcode 14 sets output typed port to value 0 or 1, bank 2.
// R7: four settable outputs, ports 0 to 3, all in bank 2.
// R8: opcode 15 reads the line picked by port and bank 0, 1, 2.
// R9: digital lines read 0 or 1, analogue channels unsigned 16 bit.
// R10: standalone mode copies the read-port value into the accumulator.
// R11: host mode returns read value only in reply; accumulator untouched.
// R12: read-port bank 2 returns the driven state of each output.
// R13: success answers status 100; read-port reply carries the read value.
// R14: host sends address, opcode, type, bank, value msb first, checksum.
// R15: checksum is the byte sum of the eight preceding bytes.
// R16: reply is host, target, status, opcode, value msb first, checksum.
// R17: read-port bank 0 digital inputs, bank 1 analogue, bank 2 outputs.
// R18: bad port or bank gives an error status and changes nothing.
`timescale 1ns/1ps
`default_nettype none
module phc_cmd #(
	parameter logic [7:0] MODULE_ADDR = phc_pkg::DEF_MODULE_ADDR
) (
	input wire logic ref_clk_i, // clock, 200 MHz
	input wire logic rstn_i, // async reset, active low
	input wire logic autorestore_en_i, // reload user variables after reset
	input wire logic standalone_i, // 1: standalone program mode
	input wire logic rx_valid_i, // command byte valid
	input wire logic [7:0] rx_byte_i, // command byte
	output logic rx_ready_o, // command byte accepted
	output logic tx_valid_o, // reply byte valid
	output logic [7:0] tx_byte_o, // reply byte
	input wire logic tx_ready_i, // reply byte taken
	input wire logic [phc_pkg::NUM_IN-1:0] din_i, // digital state of input lines
	input wire phc_pkg::phc_ain_t ain_i, // analogue values of input lines
	output logic [phc_pkg::NUM_OUT-1:0] dout_o, // digital outputs
	input wire logic [phc_pkg::NUM_AXES-1:0] home_busy_i, // homing search active
	output logic [phc_pkg::NUM_AXES-1:0] home_start_o, // homing start pulse
	output logic [phc_pkg::NUM_AXES-1:0] home_stop_o, // homing stop pulse
	output logic [31:0] acc_o, // accumulator
	output logic nv_req_o, // nonvolatile access request
	output logic nv_we_o, // 1 write, 0 read
	output logic [phc_pkg::UVAR_AW-1:0] nv_addr_o, // nonvolatile address
	output logic [31:0] nv_wdata_o, // nonvolatile write data
	input wire logic [31:0] nv_rdata_i, // nonvolatile read data
	input wire logic nv_ack_i, // nonvolatile access done
	input wire logic [phc_pkg::UVAR_AW-1:0] uvar_addr_i, // working variable read address
	output logic [31:0] uvar_data_o // working variable read data
);
	import phc_pkg::*;

	phc_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [63:0] raw_q, raw_d;
	logic [7:0] sum_q, sum_d;
	logic csum_ok_q, csum_ok_d;
	logic [71:0] tx_q, tx_d;
	logic [NUM_OUT-1:0] dout_q, dout_d;
	logic [31:0] acc_q, acc_d;
	logic boot_q, boot_d;
	logic [UVAR_AW-1:0] nv_addr_q, nv_addr_d;
	logic [31:0] nv_wdata_q, nv_wdata_d;
	logic [NUM_AXES-1:0] hstart_q, hstart_d, hstop_q, hstop_d;
	logic mem_we;
	logic [UVAR_AW-1:0] mem_addr;
	logic [31:0] mem_rdata;
	phc_frame_s frm;
	logic [7:0] status;
	logic [31:0] value;
	logic [31:0] port_val;
	logic port_ok;

	assign frm = phc_frame_s'(raw_q);

	function automatic logic [71:0] build_reply(input logic [7:0] st, input logic [7:0] op,
		input logic [31:0] val, input logic [7:0] addr);
		logic [63:0] body;
		logic [7:0] s;
		body = {HOST_ADDR, addr, st, op, val};
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + body[8*i +: 8]; // R15
		end
		return {body, s}; // R16
	endfunction : build_reply

	phc_uvar_mem u_mem (
		.ref_clk_i(ref_clk_i),
		.a_we_i(mem_we),
		.a_addr_i(mem_addr),
		.a_wdata_i(nv_rdata_i),
		.a_rdata_o(mem_rdata),
		.b_addr_i(uvar_addr_i),
		.b_rdata_o(uvar_data_o)
	);

	// read-port source selection
	always_comb begin
		port_val = VAL_ZERO;
		port_ok = (frm.typ < PORT_COUNT); // R18
		case (frm.bank)
			BANK_DIN: port_val = {31'h0000_0000, din_i[frm.typ[1:0]]}; // R9 R17
			BANK_AIN: port_val = {PAD16, ain_i[frm.typ[1:0]]}; // R9 R17
			BANK_DOUT: port_val = {31'h0000_0000, dout_q[frm.typ[1:0]]}; // R12 R17
			default: port_ok = 1'b0; // R18
		endcase
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		raw_d = raw_q;
		sum_d = sum_q;
		csum_ok_d = csum_ok_q;
		tx_d = tx_q;
		dout_d = dout_q;
		acc_d = acc_q;
		boot_d = boot_q;
		nv_addr_d = nv_addr_q;
		nv_wdata_d = nv_wdata_q;
		hstart_d = '0;
		hstop_d = '0;
		mem_we = 1'b0;
		mem_addr = (state_q == S_NV_RD) ? nv_addr_q : frm.typ;
		status = ST_OK; // R13
		value = VAL_ZERO;
		case (state_q)
			S_BOOT: begin
				// strap-like level is looked at only after reset release
				if (autorestore_en_i) begin
					boot_d = 1'b1; // R3
					nv_addr_d = UVAR_FIRST;
					state_d = S_NV_RD;
				end else begin
					state_d = S_RX;
				end
			end
			S_RX: begin
				if (rx_valid_i) begin
					if (cnt_q == CNT_LAST) begin
						cnt_d = CNT_ZERO;
						sum_d = 8'h00;
						csum_ok_d = (sum_q == rx_byte_i); // R15
						// frames for another address are dropped silently
						if (frm.target == MODULE_ADDR) begin
							state_d = S_EXEC;
						end
					end else begin
						raw_d = {raw_q[55:0], rx_byte_i}; // R14
						sum_d = sum_q + rx_byte_i; // R15
						cnt_d = cnt_q + CNT_ONE;
					end
				end
			end
			S_EXEC: begin
				state_d = S_TX;
				if (!csum_ok_q) begin
					status = ST_BAD_CSUM; // R15
				end else begin
					case (frm.opcode)
						OP_STORE_UVAR: begin
							if (frm.bank != BANK_UVAR) begin
								status = ST_BAD_VALUE; // R18
							end else begin
								nv_addr_d = frm.typ; // R1
								state_d = S_MEM_RD;
							end
						end
						OP_RESTORE_UVAR: begin
							if (frm.bank != BANK_UVAR) begin
								status = ST_BAD_VALUE; // R18
							end else begin
								nv_addr_d = frm.typ; // R2
								state_d = S_NV_RD;
							end
						end
						OP_HOMING: begin
							if (frm.bank >= AXIS_COUNT) begin
								status = ST_BAD_VALUE; // R18
							end else begin
								case (frm.typ)
									HOME_START: hstart_d[frm.bank[1:0]] = 1'b1; // R4
									HOME_STOP: hstop_d[frm.bank[1:0]] = 1'b1; // R4
									HOME_STATUS: begin
										value = home_busy_i[frm.bank[1:0]] ? VAL_ONE : VAL_ZERO; // R5
									end
									default: status = ST_BAD_TYPE;
								endcase
							end
						end
						OP_SET_OUTPUT: begin
							if (frm.bank != BANK_DOUT) begin
								status = ST_BAD_VALUE; // R18
							end else if (frm.typ >= PORT_COUNT) begin
								status = ST_BAD_TYPE; // R18
							end else if (frm.value > VAL_ONE) begin
								status = ST_BAD_VALUE;
							end else begin
								dout_d[frm.typ[1:0]] = frm.value[0]; // R6 R7
							end
						end
						OP_READ_PORT: begin
							if (!port_ok) begin
								status = ST_BAD_TYPE; // R18
							end else begin
								value = port_val; // R8 R13
								if (standalone_i) begin
									acc_d = port_val; // R10
								end // R11
							end
						end
						default: status = ST_BAD_CMD;
					endcase
				end
				tx_d = build_reply(status, frm.opcode, value, MODULE_ADDR);
			end
			S_MEM_RD: begin
				// working value is valid one cycle after the address
				nv_wdata_d = mem_rdata; // R1
				state_d = S_NV_WR;
			end
			S_NV_WR: begin
				if (nv_ack_i) begin
					tx_d = build_reply(ST_OK, frm.opcode, VAL_ZERO, MODULE_ADDR); // R13
					state_d = S_TX;
				end
			end
			S_NV_RD: begin
				if (nv_ack_i) begin
					mem_we = 1'b1; // R2 R3
					if (!boot_q) begin
						tx_d = build_reply(ST_OK, frm.opcode, VAL_ZERO, MODULE_ADDR);
						state_d = S_TX;
					end else if (nv_addr_q == UVAR_LAST) begin
						boot_d = 1'b0;
						state_d = S_RX;
					end else begin
						nv_addr_d = nv_addr_q + 8'h01; // R3
					end
				end
			end
			S_TX: begin
				if (tx_ready_i) begin
					tx_d = {tx_q[63:0], 8'h00}; // R16
					if (cnt_q == CNT_LAST) begin
						cnt_d = CNT_ZERO;
						state_d = S_RX;
					end else begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
			end
			default: state_d = S_RX;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= S_BOOT;
			cnt_q <= CNT_ZERO;
			raw_q <= '0;
			sum_q <= 8'h00;
			csum_ok_q <= 1'b0;
			tx_q <= '0;
			dout_q <= '0;
			acc_q <= VAL_ZERO;
			boot_q <= 1'b0;
			nv_addr_q <= UVAR_FIRST;
			nv_wdata_q <= VAL_ZERO;
			hstart_q <= '0;
			hstop_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			raw_q <= raw_d;
			sum_q <= sum_d;
			csum_ok_q <= csum_ok_d;
			tx_q <= tx_d;
			dout_q <= dout_d;
			acc_q <= acc_d;
			boot_q <= boot_d;
			nv_addr_q <= nv_addr_d;
			nv_wdata_q <= nv_wdata_d;
			hstart_q <= hstart_d;
			hstop_q <= hstop_d;
		end
	end

	assign rx_ready_o = (state_q == S_RX);
	assign tx_valid_o = (state_q == S_TX);
	assign tx_byte_o = tx_q[71:64];
	assign dout_o = dout_q;
	assign acc_o = acc_q;
	assign home_start_o = hstart_q;
	assign home_stop_o = hstop_q;
	assign nv_req_o = (state_q == S_NV_RD) || (state_q == S_NV_WR);
	assign nv_we_o = (state_q == S_NV_WR);
	assign nv_addr_o = nv_addr_q;
	assign nv_wdata_o = nv_wdata_q;
endmodule : phc_cmd
`default_nettype wire

// file: testbench/phc_nv_model.sv
`timescale 1ns/1ps
`default_nettype none
module phc_nv_model #(
	parameter int DLY = 2
) (
	input wire logic clk_i, // clock
	input wire logic req_i, // request
	input wire logic we_i, // 1 write
	input wire logic [7:0] addr_i, // word address
	input wire logic [31:0] wdata_i, // write data
	output logic [31:0] rdata_o, // read data
	output logic ack_o // done pulse
);
	logic [31:0] mem [256];
	logic [7:0] wa_q;
	logic [31:0] wd_q;
	int cnt;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 32'h5a5a_0000 | 32'(i);
		ack_o = 1'b0;
		rdata_o = '0;
		cnt = 0;
	end
	always @(posedge clk_i) begin
		if (ack_o) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o; // stale word must not look valid
			cnt <= 0;
		end else if (req_i && cnt == DLY) begin
			ack_o <= 1'b1;
			if (we_i) begin
				mem[addr_i] <= wdata_i;
				wa_q <= addr_i;
				wd_q <= wdata_i;
			end else rdata_o <= mem[addr_i];
		end else if (req_i) cnt <= cnt + 1;
	end
endmodule : phc_nv_model
`default_nettype wire

// file: testbench/phc_cmd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module phc_cmd_monitor (
	input wire logic ref_clk_i, // clock
	input wire logic rstn_i, // reset
	input wire logic standalone_i, // mode
	input wire logic tx_ready_i, // reply taken
	input wire logic rx_ready_o, // byte taken
	input wire logic tx_valid_o, // reply valid
	input wire logic [7:0] tx_byte_o, // reply byte
	input wire logic [phc_pkg::NUM_OUT-1:0] dout_o, // outputs
	input wire logic [phc_pkg::NUM_AXES-1:0] home_start_o, // start
	input wire logic [phc_pkg::NUM_AXES-1:0] home_stop_o, // stop
	input wire logic [31:0] acc_o, // accumulator
	input wire logic nv_req_o, // nv request
	input wire logic nv_ack_i, // nv done
	input wire logic [phc_pkg::UVAR_AW-1:0] nv_addr_o // nv address
);
	import phc_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_stall; tx_valid_o && !tx_ready_i; endsequence
	sequence s_start; home_start_o != '0; endsequence
	sequence s_nv_wait; nv_req_o && !nv_ack_i; endsequence
	sequence s_reply_go; $rose(tx_valid_o); endsequence
	property p_rx_tx_excl; rx_ready_o |-> !tx_valid_o; endproperty
	a_rx_tx_excl: assert property (p_rx_tx_excl)
		else $error("receive and reply overlap");
	property p_reply_head; s_reply_go |-> tx_byte_o == HOST_ADDR; endproperty
	a_reply_head: assert property (p_reply_head)
		else $error("reply does not open with host address");
	property p_tx_hold; s_stall |=> tx_valid_o && $stable(tx_byte_o); endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("reply byte dropped while stalled");
	property p_start_pulse; s_start |=> home_start_o == '0; endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start pulse too long");
	property p_home_excl; (home_start_o & home_stop_o) == '0; endproperty
	a_home_excl: assert property (p_home_excl)
		else $error("start and stop together");
	property p_dout_cause; $changed(dout_o) |-> ##[0:1] tx_valid_o; endproperty
	a_dout_cause: assert property (p_dout_cause)
		else $error("output moved outside a command");
	property p_acc_mode; $changed(acc_o) |-> standalone_i; endproperty
	a_acc_mode: assert property (p_acc_mode)
		else $error("accumulator moved in host mode");
	property p_nv_hold; s_nv_wait |=> nv_req_o && $stable(nv_addr_o); endproperty
	a_nv_hold: assert property (p_nv_hold)
		else $error("nv request not held");
endmodule : phc_cmd_monitor
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import phc_pkg::*;
	logic ref_clk_i, rstn_i, autorestore_en_i, standalone_i, rx_valid_i, tx_ready_i;
	logic rx_ready_o, tx_valid_o, nv_req_o, nv_we_o, nv_ack_i;
	logic [7:0] rx_byte_i, tx_byte_o, uvar_addr_i, nv_addr_o, st, tgt;
	logic [3:0] din_i, dout_o;
	phc_ain_t ain_i;
	logic [2:0] home_busy_i, home_start_o, home_stop_o, hs, hp;
	logic [31:0] acc_o, nv_wdata_o, nv_rdata_i, uvar_data_o, rv;
	int miscompares, tests_run;
	phc_cmd phc_cmd_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .autorestore_en_i(autorestore_en_i),
		.standalone_i(standalone_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
		.rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
		.tx_ready_i(tx_ready_i), .din_i(din_i), .ain_i(ain_i), .dout_o(dout_o),
		.home_busy_i(home_busy_i), .home_start_o(home_start_o), .home_stop_o(home_stop_o),
		.acc_o(acc_o), .nv_req_o(nv_req_o), .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o),
		.nv_wdata_o(nv_wdata_o), .nv_rdata_i(nv_rdata_i), .nv_ack_i(nv_ack_i),
		.uvar_addr_i(uvar_addr_i), .uvar_data_o(uvar_data_o));
	phc_nv_model nv_model_i (.clk_i(ref_clk_i), .req_i(nv_req_o), .we_i(nv_we_o),
		.addr_i(nv_addr_o), .wdata_i(nv_wdata_o), .rdata_o(nv_rdata_i), .ack_o(nv_ack_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (home_start_o != '0) hs <= home_start_o;
		if (home_stop_o != '0) hp <= home_stop_o;
	end
	task summarize;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk
	task wt(input bit tx);
		for (int k = 0; !(tx ? tx_valid_o : rx_ready_o); k++) begin
			@(negedge ref_clk_i);
			if (k > 3000) begin
				miscompares++;
				summarize();
			end
		end
	endtask : wt
	task automatic cmd(input logic [7:0] op, t, b, input logic [31:0] v, input logic [7:0] bad);
		logic [7:0] f [9];
		logic [7:0] r [9];
		logic [7:0] s;
		f = '{tgt, op, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		s = '0;
		for (int i = 0; i < 8; i++) s += f[i];
		f[8] = s + bad;
		for (int i = 0; i < 9; i++) begin
			@(negedge ref_clk_i);
			rx_valid_i = 1'b1;
			rx_byte_i = f[i];
			wt(1'b0);
			@(posedge ref_clk_i);
		end
		// a frame for another address must stay unanswered
		if (tgt != 8'h01) begin
			@(negedge ref_clk_i);
			rx_valid_i = 1'b0;
			repeat (12) begin
				@(negedge ref_clk_i);
				chk("no reply", 32'h0000_0000, 32'(tx_valid_o));
			end
			return;
		end
		for (int i = 0; i < 9; i++) begin
			@(negedge ref_clk_i);
			rx_valid_i = 1'b0;
			rx_byte_i = ~f[8];
			wt(1'b1);
			if (i == 4) begin
				tx_ready_i = 1'b0; // stall one byte
				@(negedge ref_clk_i);
				tx_ready_i = 1'b1;
			end
			r[i] = tx_byte_o;
		end
		s = '0;
		for (int i = 0; i < 8; i++) s += r[i];
		chk("reply head", {HOST_ADDR, 8'h01, op, s}, {r[0], r[1], r[3], r[8]});
		st = r[2];
		rv = {r[4], r[5], r[6], r[7]};
	endtask : cmd
	task t_boot;
		wt(1'b0);
		uvar_addr_i = 8'h2a;
		@(negedge ref_clk_i);
		chk("restored var", 32'h5a5a_002a, uvar_data_o);
	endtask : t_boot
	task t_out;
		for (int p = 0; p < 4; p++) begin
			cmd(OP_SET_OUTPUT, 8'(p), BANK_DOUT, VAL_ONE, 8'h00);
			chk("set status", 32'(ST_OK), 32'(st));
			chk("dout bit", VAL_ONE, 32'(dout_o[p]));
			cmd(OP_READ_PORT, 8'(p), BANK_DOUT, VAL_ZERO, 8'h00);
			chk("out state", VAL_ONE, rv);
		end
		cmd(OP_SET_OUTPUT, 8'h03, BANK_DOUT, VAL_ZERO, 8'h00);
		chk("dout clear", 32'h0000_0007, 32'(dout_o));
	endtask : t_out
	task t_read;
		din_i = 4'h4;
		cmd(OP_READ_PORT, 8'h02, BANK_DIN, VAL_ZERO, 8'h00);
		chk("din 2", VAL_ONE, rv);
		cmd(OP_READ_PORT, 8'h01, BANK_DIN, VAL_ZERO, 8'h00);
		chk("din 1", VAL_ZERO, rv);
		chk("acc host", VAL_ZERO, acc_o);
		standalone_i = 1'b1;
		cmd(OP_READ_PORT, 8'h01, BANK_AIN, 32'hffff_ffff, 8'h00);
		chk("ain 1", 32'h0000_beef, rv);
		chk("acc", 32'h0000_beef, acc_o);
		standalone_i = 1'b0;
		// a host-mode read of a nonzero line must not disturb the loaded value
		cmd(OP_READ_PORT, 8'h02, BANK_DIN, VAL_ZERO, 8'h00);
		chk("acc kept", 32'h0000_beef, acc_o);
	endtask : t_read
	task t_home;
		cmd(OP_HOMING, HOME_START, 8'h01, VAL_ZERO, 8'h00);
		chk("start", 32'h0000_0002, 32'(hs));
		cmd(OP_HOMING, HOME_STOP, 8'h02, VAL_ZERO, 8'h00);
		chk("stop", 32'h0000_0004, 32'(hp));
		home_busy_i = 3'h1;
		cmd(OP_HOMING, HOME_STATUS, 8'h00, VAL_ZERO, 8'h00);
		chk("busy", VAL_ONE, 32'(rv != VAL_ZERO));
		cmd(OP_HOMING, HOME_STATUS, 8'h01, VAL_ZERO, 8'h00);
		chk("idle", VAL_ZERO, rv);
	endtask : t_home
	task automatic t_err;
		// op type bank value checksum-skew status
		logic [47:0] e [9] = '{48'h0e00_0200_0101, 48'h0e04_0201_0003, 48'h0e00_0202_0004,
			48'h0e03_0101_0004, 48'h0f00_0300_0003, 48'h0d00_0300_0004, 48'h1000_0000_0002,
			48'h0b2a_0000_0004, 48'h0d03_0000_0003};
		for (int i = 0; i < 9; i++) begin
			cmd(e[i][47:40], e[i][39:32], e[i][31:24], 32'(e[i][23:16]), e[i][15:8]);
			chk("err status", 32'(e[i][7:0]), 32'(st));
		end
		chk("dout kept", 32'h0000_0007, 32'(dout_o));
	endtask : t_err
	task t_nv;
		cmd(OP_STORE_UVAR, 8'h2a, BANK_UVAR, 32'hdead_beef, 8'h00);
		chk("store status", 32'(ST_OK), 32'(st));
		chk("store word", 32'h5a5a_002a, nv_model_i.wd_q);
		chk("store addr", 32'h0000_002a, 32'(nv_model_i.wa_q));
		nv_model_i.mem[42] = 32'h1234_5678;
		cmd(OP_RESTORE_UVAR, 8'h2a, BANK_UVAR, VAL_ZERO, 8'h00);
		@(negedge ref_clk_i);
		chk("restored", 32'h1234_5678, uvar_data_o);
	endtask : t_nv
	task t_rst;
		// second reset without reload: link must open at once, outputs cleared
		autorestore_en_i = 1'b0;
		rstn_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		@(negedge ref_clk_i);
		chk("dout reset", 32'h0000_0000, 32'(dout_o));
		@(negedge ref_clk_i);
		chk("no reload", 32'h0000_0002, 32'({rx_ready_o, nv_req_o}));
	endtask : t_rst
	task t_addr;
		tgt = 8'h05;
		cmd(OP_SET_OUTPUT, 8'h00, BANK_DOUT, VAL_ONE, 8'h00);
		tgt = 8'h01;
		chk("foreign frame", 32'h0000_0000, 32'(dout_o));
		cmd(OP_SET_OUTPUT, 8'h00, BANK_DOUT, VAL_ONE, 8'h00);
		chk("dout after reset", VAL_ONE, 32'(dout_o));
	endtask : t_addr
	initial begin
		{rstn_i, standalone_i, rx_valid_i, rx_byte_i, din_i, ain_i} = '0;
		{home_busy_i, uvar_addr_i, hs, hp} = '0;
		tgt = 8'h01;
		{autorestore_en_i, tx_ready_i} = 2'b11;
		miscompares = 0;
		tests_run = 0;
		ain_i[1] = 16'hbeef;
		repeat (6) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		t_boot();
		t_out();
		t_read();
		t_home();
		t_err();
		t_nv();
		t_rst();
		t_addr();
		summarize();
	end
endmodule : testbench
bind phc_cmd phc_cmd_monitor phc_cmd_monitor_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
	.standalone_i(standalone_i), .tx_ready_i(tx_ready_i), .rx_ready_o(rx_ready_o),
	.tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .dout_o(dout_o),
	.home_start_o(home_start_o), .home_stop_o(home_stop_o), .acc_o(acc_o),
	.nv_req_o(nv_req_o), .nv_ack_i(nv_ack_i), .nv_addr_o(nv_addr_o));
`default_nettype wire
